// ### common/tlbc_pkg.sv
package tlbc_pkg;
    localparam logic [7:0]  CMD_SET_TEAR_LINE  = 8'h44;
    localparam logic [7:0]  CMD_READ_SCAN_LINE = 8'h45;
    localparam logic [7:0]  CMD_WRITE_BRIGHT   = 8'h51;
    localparam logic [7:0]  CMD_READ_BRIGHT    = 8'h52;
    localparam logic [7:0]  CMD_WRITE_CTRL     = 8'h53;
    localparam logic [7:0]  CMD_SLEEP_IN       = 8'h10;
    localparam logic [7:0]  CMD_SLEEP_OUT      = 8'h11;
    localparam logic [7:0]  CMD_SOFT_RESET     = 8'h01;
    localparam logic [7:0]  CMD_TEAR_OFF       = 8'h34;
    localparam logic [7:0]  CMD_TEAR_ON        = 8'h35;
    localparam int          CTRL_BLOCK_BIT     = 5;
    localparam int          CTRL_DIM_BIT       = 3;
    localparam int          CTRL_BL_BIT        = 2;
    localparam logic [15:0] TEAR_LINE_RST      = 16'h0000;
    localparam logic [7:0]  BRIGHT_RST         = 8'h00;
    localparam logic [7:0]  CTRL_RST           = 8'h00;
    localparam int          LINE_CLK_DIV       = 64;
    localparam int          VSYNC_LINES        = 2;
    localparam int          VBP_LINES          = 2;
    localparam int          ACT_LINES          = 480;
    localparam int          VFP_LINES          = 4;
    typedef enum logic [1:0] {
        TLBC_PH0 = 2'b00,
        TLBC_PH1 = 2'b01,
        TLBC_PH2 = 2'b11,
        TLBC_PH3 = 2'b10
    } tlbc_phase_t;
endpackage

// ### rtl/tlbc_core.sv
`timescale 1ns/1ps
// Function
// - Command 44h then two parameters, high byte first, form tear line
// - Tear line command enables frame sync, pulsed at that scan line
// - Frame sync timing ignores memory access control bit B4
// - Tear line zero behaves like tearing-effect-on with mode zero
// - Frame sync held low while in sleep mode
// - Tear line command ignored when frame sync already enabled
// - Command 45h: dummy read, then line high byte, then low byte
// - Scan line read returns the line currently being scanned
// - Frame spans sync plus back porch plus active plus front porch lines
// - First sync line is line zero, counting upward
// - Scan line read value in sleep is unspecified
// - Command 51h with one parameter byte writes brightness level
// - Backlight PWM output derived from brightness setting
// - Brightness monotonic: 00h lowest, FFh highest
// - Command 52h: dummy read, then brightness byte; serial reads skip the dummy slot
// - Brightness level cleared on entering sleep
// - Brightness read returns zero when block is off
// - Block on and adaptive mode zero: read returns last 51h value
// - Extra parallel reads after 52h keep returning brightness byte
// - 53h parameter: D5 block on, D3 dimming, D2 backlight
// - Block off forces effective brightness to 00h
// - Dimming applies only to manual brightness; no dimming is modelled, D3 only drives dimming_enable
module tlbc_core
    import tlbc_pkg::*;
#(
    parameter int LINE_DIV   = LINE_CLK_DIV,
    parameter int VSYNC      = VSYNC_LINES,
    parameter int VERTICAL_BACK_PORCH        = VBP_LINES,
    parameter int ACTIVE_LINES       = ACT_LINES,
    parameter int VERTICAL_FRONT_PORCH        = VFP_LINES
) (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        cmd_param_select,
    input  wire logic        write_strobe_n,
    input  wire logic        read_strobe_n,
    input  wire logic        parallel_serial_select,
    input  wire logic [7:0]  data_in,
    input  wire logic [1:0]  content_adaptive_mode,
    output logic      [7:0]  data_out,
    output logic             data_out_en_n,
    output logic             frame_sync_output,
    output logic             backlight_pwm,
    output logic             backlight_on,
    output logic             dimming_enable,
    output logic             brightness_block_on,
    output logic             sleep_mode
);
    localparam int TOTAL = VSYNC + VERTICAL_BACK_PORCH + ACTIVE_LINES + VERTICAL_FRONT_PORCH;
    initial begin
        if (TOTAL > 65535 || TOTAL < 2 || LINE_DIV < 1 || LINE_DIV > 65535)
            $error("tlbc_core: unsupported frame geometry");
    end
    // All checks below share this one clock and reset
    default clocking tlbc_clk @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers and strobe edges
    logic [3:0] s1_ff;
    logic [3:0] s2_ff;
    logic [1:0] strb_ff;
    logic [7:0] d1_ff;
    logic [7:0] d2_ff;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s1_ff   <= 4'hF;
            s2_ff   <= 4'hF;
            strb_ff <= 2'h3;
            d1_ff   <= 8'h00;
            d2_ff   <= 8'h00;
        end else begin
            s1_ff   <= {cmd_param_select, write_strobe_n, read_strobe_n,
                        parallel_serial_select};
            s2_ff   <= s1_ff;
            strb_ff <= s2_ff[2:1];
            d1_ff   <= data_in;
            d2_ff   <= d1_ff;
        end
    end
    wire dcx_s  = s2_ff[3];
    wire par_s  = s2_ff[0];
    // Rising edge of a strobe marks the access, as on the bus pins
    wire wr_evt = s2_ff[2] & ~strb_ff[1];
    wire rd_evt = s2_ff[1] & ~strb_ff[0];
    wire cmd_wr = wr_evt & ~dcx_s;
    wire par_wr = wr_evt & dcx_s;
    wire par_rd = rd_evt & dcx_s;

    ////////////////////////////////////////////////////////////////////
    // Command tracking
    logic [7:0]  cmd_ff;
    logic [1:0]  pcnt_ff;
    logic [15:0] tear_line_ff;
    logic [7:0]  tear_hi_ff;
    logic        te_en_ff;
    logic        te_armed_ff;
    logic [7:0]  bright_ff;
    logic [7:0]  ctrl_ff;
    logic        sleep_ff;
    wire soft_rst = cmd_wr && (d2_ff == CMD_SOFT_RESET);
    wire [1:0] nxt_pcnt = (pcnt_ff == 2'h3) ? pcnt_ff : pcnt_ff + 2'h1;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cmd_ff  <= 8'h00;
            pcnt_ff <= 2'h0;
        end else if (cmd_wr) begin
            cmd_ff  <= d2_ff;
            pcnt_ff <= 2'h0;
        end else if (par_wr || par_rd) begin
            pcnt_ff <= nxt_pcnt;
        end
    end
    wire tl_hi_wr = par_wr && cmd_ff == CMD_SET_TEAR_LINE && pcnt_ff == 2'h0;
    wire tl_lo_wr = par_wr && cmd_ff == CMD_SET_TEAR_LINE && pcnt_ff == 2'h1;
    wire tl_start = cmd_wr && d2_ff == CMD_SET_TEAR_LINE;
    wire te_on    = cmd_wr && d2_ff == CMD_TEAR_ON;
    wire te_off   = cmd_wr && d2_ff == CMD_TEAR_OFF;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tear_line_ff <= TEAR_LINE_RST;
            tear_hi_ff   <= 8'h00;
            te_en_ff     <= 1'b0;
            te_armed_ff  <= 1'b0;
        end else begin
            if (tl_start)
                te_armed_ff <= ~te_en_ff;
            if (tl_hi_wr && te_armed_ff)
                tear_hi_ff <= d2_ff;
            if (tl_lo_wr && te_armed_ff) begin
                tear_line_ff <= {tear_hi_ff, d2_ff};
                te_en_ff     <= 1'b1;
                te_armed_ff  <= 1'b0;
            end
            if (te_on)
                tear_line_ff <= 16'h0000;
            if (te_on)
                te_en_ff <= 1'b1;
            if (te_off || soft_rst)
                te_en_ff <= 1'b0;
        end
    end

    wire bright_wr = par_wr && cmd_ff == CMD_WRITE_BRIGHT && pcnt_ff == 2'h0;
    wire ctrl_wr   = par_wr && cmd_ff == CMD_WRITE_CTRL && pcnt_ff == 2'h0;
    wire sleep_in  = cmd_wr && d2_ff == CMD_SLEEP_IN;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            bright_ff <= BRIGHT_RST;
            ctrl_ff   <= CTRL_RST;
            sleep_ff  <= 1'b1;
        end else begin
            if (bright_wr)
                bright_ff <= d2_ff;
            if (ctrl_wr)
                ctrl_ff <= d2_ff & 8'h2C;
            if (sleep_in || soft_rst)
                bright_ff <= BRIGHT_RST;
            if (soft_rst)
                ctrl_ff <= CTRL_RST;
            if (sleep_in || soft_rst)
                sleep_ff <= 1'b1;
            else if (cmd_wr && d2_ff == CMD_SLEEP_OUT)
                sleep_ff <= 1'b0;
        end
    end
    assign brightness_block_on = ctrl_ff[CTRL_BLOCK_BIT];
    // Dimming is only a flag; the manual level path never reads it
    assign dimming_enable      = ctrl_ff[CTRL_DIM_BIT];
    assign backlight_on        = ctrl_ff[CTRL_BL_BIT];
    assign sleep_mode          = sleep_ff;

    ////////////////////////////////////////////////////////////////////
    // Scan line timing: line enable from a divider, then the line counter
    logic [15:0] div_ff;
    logic [15:0] line_ff;
    wire line_en = (div_ff == 16'(LINE_DIV - 1));
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            div_ff  <= 16'h0000;
            line_ff <= 16'h0000;
        end else begin
            div_ff <= line_en ? 16'h0000 : div_ff + 16'h0001;
            if (line_en)
                line_ff <= (line_ff == 16'(TOTAL - 1)) ? 16'h0000
                                                       : line_ff + 16'h0001;
        end
    end
    // Timing never looks at memory access control, only the line count
    wire nxt_te = te_en_ff && !sleep_ff && line_ff == tear_line_ff;
    logic te_ff;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            te_ff <= 1'b0;
        else
            te_ff <= nxt_te;
    end
    assign frame_sync_output = te_ff;

    ////////////////////////////////////////////////////////////////////
    // Effective brightness and PWM
    // Dimming ramp is not modelled; manual level takes effect at once
    wire [7:0] eff_bright = brightness_block_on ? bright_ff : 8'h00;
    logic [7:0] pwm_cnt_ff;
    logic       pwm_ff;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pwm_cnt_ff <= 8'h00;
            pwm_ff     <= 1'b0;
        end else begin
            pwm_cnt_ff <= pwm_cnt_ff + 8'h01;
            // Duty is eff/256; FFh still has one low slot per period
            pwm_ff <= backlight_on && (pwm_cnt_ff < eff_bright);
        end
    end
    assign backlight_pwm = pwm_ff;

    ////////////////////////////////////////////////////////////////////
    // Read data path
    wire [7:0] rd_bright =
        (brightness_block_on && content_adaptive_mode == 2'h0)
        ? bright_ff : 8'h00;
    logic [7:0] nxt_dout;
    always_comb begin
        nxt_dout = 8'h00;
        if (cmd_ff == CMD_READ_SCAN_LINE) begin
            if (pcnt_ff == 2'h1)
                nxt_dout = line_ff[15:8];
            else if (pcnt_ff == 2'h2)
                nxt_dout = line_ff[7:0];
        end else if (cmd_ff == CMD_READ_BRIGHT) begin
            // Serial reads skip the dummy slot
            if (pcnt_ff != 2'h0 || !par_s)
                nxt_dout = rd_bright;
        end
    end
    logic [7:0] dout_ff;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            dout_ff <= 8'h00;
        else
            dout_ff <= nxt_dout;
    end
    assign data_out      = dout_ff;
    assign data_out_en_n = ~(~s2_ff[1] & dcx_s);

    ////////////////////////////////////////////////////////////////////
    // Checks
    sleep_low_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        sleep_ff |=> !frame_sync_output)
        else $error("frame sync active in sleep");
    te_line_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        frame_sync_output |-> $past(line_ff) == $past(tear_line_ff))
        else $error("frame sync on wrong line");
    te_ignore_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (te_en_ff && tl_lo_wr && !te_on) |=> $stable(tear_line_ff))
        else $error("tear line changed while enabled");
    line_wrap_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (line_en && line_ff == 16'(TOTAL - 1)) |=> line_ff == 16'h0000)
        else $error("scan line wrap wrong");
    block_off_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        !brightness_block_on |=> !backlight_pwm)
        else $error("pwm active with block off");
    sleep_clear_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        sleep_in |=> bright_ff == 8'h00)
        else $error("brightness kept in sleep");
    read_zero_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (cmd_ff == CMD_READ_BRIGHT && !brightness_block_on && !cmd_wr)
        |=> dout_ff == 8'h00)
        else $error("brightness read not zero");
    bright_wr_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (bright_wr && !sleep_in) |=> bright_ff == $past(d2_ff))
        else $error("brightness write lost");
    tl_pair_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (tl_lo_wr && te_armed_ff && !te_on)
        |=> tear_line_ff == {$past(tear_hi_ff), $past(d2_ff)})
        else $error("tear line assembly wrong");
    soft_keep_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (soft_rst && !te_on) |=> $stable(tear_line_ff))
        else $error("soft reset changed tear line");

    // Frame sync must drop after one line, so its run length is bounded
    logic [15:0] te_len_ff;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            te_len_ff <= 16'h0000;
        else if (frame_sync_output)
            te_len_ff <= te_len_ff + 16'h0001;
        else
            te_len_ff <= 16'h0000;
    end

    // Frame sync enable, refusal and pulse
    te_enable_a: assert property (
        (tl_lo_wr && te_armed_ff) |=> te_en_ff)
        else $error("tear line did not enable frame sync");
    te_off_a: assert property (
        (te_off || soft_rst) |=> !te_en_ff)
        else $error("frame sync still enabled");
    te_zero_a: assert property (
        te_on |=> (te_en_ff && tear_line_ff == 16'h0000))
        else $error("frame sync on is not line zero");
    te_refuse_a: assert property (
        (tl_start && te_en_ff) |=> !te_armed_ff)
        else $error("tear line command taken while enabled");
    te_pulse_a: assert property (
        (te_en_ff && !sleep_ff && line_ff == tear_line_ff)
        |=> frame_sync_output)
        else $error("frame sync missed its line");
    te_width_a: assert property (
        te_len_ff <= 16'(LINE_DIV))
        else $error("frame sync longer than one line");

    // Scan line counter
    line_step_a: assert property (
        (line_en && line_ff != 16'(TOTAL - 1))
        |=> line_ff == $past(line_ff) + 16'h0001)
        else $error("scan line did not count up");
    line_hold_a: assert property (
        !line_en |=> $stable(line_ff))
        else $error("scan line moved without line enable");
    line_range_a: assert property (
        line_ff < 16'(TOTAL))
        else $error("scan line out of frame");

    // Command and parameter tracking
    cmd_take_a: assert property (
        cmd_wr |=> (cmd_ff == $past(d2_ff) && pcnt_ff == 2'h0))
        else $error("command byte not taken");
    par_step_a: assert property (
        (par_wr && pcnt_ff != 2'h3) |=> pcnt_ff == $past(pcnt_ff) + 2'h1)
        else $error("parameter count did not advance");
    ctrl_bits_a: assert property (
        ctrl_wr |=> (brightness_block_on == $past(d2_ff[CTRL_BLOCK_BIT])
                     && dimming_enable == $past(d2_ff[CTRL_DIM_BIT])
                     && backlight_on == $past(d2_ff[CTRL_BL_BIT])))
        else $error("display control bits wrong");
    soft_clear_a: assert property (
        soft_rst |=> (bright_ff == BRIGHT_RST && ctrl_ff == CTRL_RST
                      && sleep_ff))
        else $error("soft reset left state behind");
    oen_cmd_a: assert property (
        !dcx_s |-> data_out_en_n)
        else $error("read data driven during a command");

    // Backlight PWM
    bl_off_a: assert property (
        !backlight_on |=> !backlight_pwm)
        else $error("pwm active with backlight off");
    pwm_full_a: assert property (
        (backlight_on && eff_bright == 8'hFF && pwm_cnt_ff != 8'hFF)
        |=> backlight_pwm)
        else $error("full brightness pwm low");

    // Read data
    rd_line_hi_a: assert property (
        (cmd_ff == CMD_READ_SCAN_LINE && pcnt_ff == 2'h1)
        |=> data_out == $past(line_ff[15:8]))
        else $error("scan line high byte wrong");
    rd_line_lo_a: assert property (
        (cmd_ff == CMD_READ_SCAN_LINE && pcnt_ff == 2'h2)
        |=> data_out == $past(line_ff[7:0]))
        else $error("scan line low byte wrong");
    rd_bright_a: assert property (
        (cmd_ff == CMD_READ_BRIGHT && pcnt_ff != 2'h0
         && brightness_block_on && content_adaptive_mode == 2'h0)
        |=> data_out == $past(bright_ff))
        else $error("brightness read byte wrong");
    rd_serial_a: assert property (
        (cmd_ff == CMD_READ_BRIGHT && !par_s
         && brightness_block_on && content_adaptive_mode == 2'h0)
        |=> data_out == $past(bright_ff))
        else $error("serial brightness read wrong");

    serial_rd_c: cover property (
        par_rd && !par_s && cmd_ff == CMD_READ_BRIGHT);
    te_seen_c: cover property (@(posedge sys_clk) disable iff (!rstn)
        $rose(frame_sync_output));
    tl_set_c: cover property (@(posedge sys_clk) disable iff (!rstn)
        tl_lo_wr && te_armed_ff);
    bright_rd_c: cover property (@(posedge sys_clk) disable iff (!rstn)
        par_rd && cmd_ff == CMD_READ_BRIGHT && pcnt_ff == 2'h2);
    line_rd_c: cover property (@(posedge sys_clk) disable iff (!rstn)
        par_rd && cmd_ff == CMD_READ_SCAN_LINE && pcnt_ff == 2'h2);
endmodule

// ### testbench/tlbc_host_model.sv
`timescale 1ns/1ps
module tlbc_host_model (
    input  wire logic       sys_clk,
    output logic            cmd_param_select,
    output logic            write_strobe_n,
    output logic            read_strobe_n,
    output logic            parallel_serial_select,
    output logic      [7:0] data_in
);
    initial begin
        cmd_param_select = 1'b1;
        write_strobe_n = 1'b1;
        read_strobe_n = 1'b1;
        parallel_serial_select = 1'b1;
        data_in = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////
    // One write slot; bytes go out in the order the caller sends them
    task automatic put(input logic dc, input logic [7:0] b);
        @(posedge sys_clk) #1;
        cmd_param_select = dc;
        data_in = b;
        write_strobe_n = 1'b0;
        repeat (5) @(posedge sys_clk);
        #1 write_strobe_n = 1'b1;
        repeat (5) @(posedge sys_clk);
        // Released bus shows the inverse so stale data cannot pass
        #1 data_in = ~b;
    endtask
    // One read slot; dummy slots are the caller's business
    task automatic get();
        @(posedge sys_clk) #1;
        cmd_param_select = 1'b1;
        read_strobe_n = 1'b0;
        repeat (6) @(posedge sys_clk);
        #1 read_strobe_n = 1'b1;
        repeat (5) @(posedge sys_clk);
    endtask
    task automatic mode(input logic p);
        @(posedge sys_clk) #1 parallel_serial_select = p;
    endtask
endmodule

// ### testbench/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
    $display("BAD %0t got %h exp %h", $time, a, b); end end
module tb_top;
    import tlbc_pkg::*;
    localparam int DIV   = 4;
    localparam int FRAME = (VSYNC_LINES + VBP_LINES + ACT_LINES
                            + VFP_LINES) * DIV;
    typedef struct packed {logic [7:0] v; logic [7:0] m;} tlbc_note_t;
    logic       sys_clk = 1'b0;
    logic       rstn = 1'b0;
    logic       cps, wr_n, rd_n, pss, fso, pwm, bl, dim, blk, slp, oen_n;
    logic [7:0] din, dout, lvl;
    logic [1:0] cam = 2'b00;
    tlbc_note_t notes[$];
    tlbc_note_t nt;
    int         bad_count = 0;
    int         tests_run = 0;
    int         c;
    time        t0;
    logic [7:0] ctl_tab[5] = '{8'h2C, 8'hD3, 8'h20, 8'h08, 8'h04};
    logic [7:0] pwm_tab[3];

    always #4 sys_clk = ~sys_clk;
    tlbc_host_model host (.sys_clk(sys_clk), .cmd_param_select(cps),
        .write_strobe_n(wr_n), .read_strobe_n(rd_n),
        .parallel_serial_select(pss), .data_in(din));
    tlbc_core #(.LINE_DIV(DIV)) DUT (.sys_clk(sys_clk), .rstn(rstn),
        .cmd_param_select(cps), .write_strobe_n(wr_n),
        .read_strobe_n(rd_n), .parallel_serial_select(pss),
        .data_in(din), .content_adaptive_mode(cam), .data_out(dout),
        .data_out_en_n(oen_n), .frame_sync_output(fso),
        .backlight_pwm(pwm), .backlight_on(bl), .dimming_enable(dim),
        .brightness_block_on(blk), .sleep_mode(slp));
    ////////////////////////////////////////////////////////////////////
    // Read byte is judged at the end of its slot, against the oldest note
    always @(posedge rd_n) begin
        if (notes.size() != 0) begin
            nt = notes.pop_front();
            `CHK(dout & nt.m, nt.v)
            `CHK(oen_n, 1'b0)
        end
    end
    task automatic note(input logic [7:0] v, input logic [7:0] m);
        notes.push_back('{v, m});
    endtask
    task automatic wr2(input logic [7:0] cm, input logic [7:0] p);
        host.put(1'b0, cm);
        host.put(1'b1, p);
    endtask
    task automatic rd52(input int k, input logic [7:0] v, input bit dum);
        host.put(1'b0, CMD_READ_BRIGHT);
        if (dum) begin
            note(8'h00, 8'h00);
            host.get();
        end
        repeat (k) begin
            note(v, 8'hFF);
            host.get();
        end
    endtask
    // Counts high cycles of frame sync (sel) or backlight PWM
    task automatic cnt(input int len, input bit sel);
        c = 0;
        repeat (len) begin
            @(posedge sys_clk) #1;
            c += sel ? (fso === 1'b1) : (pwm === 1'b1);
        end
    endtask
    task automatic wait_rise();
        c = 0;
        while (fso !== 1'b0 && c < 9000) begin
            @(posedge sys_clk) #1;
            c++;
        end
        while (fso !== 1'b1 && c < 9000) begin
            @(posedge sys_clk) #1;
            c++;
        end
        `CHK(c < 9000, 1'b1)
    endtask
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Run should finish near 10k cycles; 50k cycles means a hang
    initial begin
        #400_000;
        bad_count++;
        wrap_up();
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(22651));
        repeat (5) @(posedge sys_clk);
        #1 rstn = 1'b1;
        repeat (3) @(posedge sys_clk);
        `CHK({blk, dim, bl, pwm, fso, slp, oen_n}, 7'b0000011)
        host.put(1'b0, CMD_SLEEP_OUT);
        `CHK(slp, 1'b0)
        foreach (ctl_tab[i]) begin
            wr2(CMD_WRITE_CTRL, ctl_tab[i]);
            `CHK({blk, dim, bl}, {ctl_tab[i][5], ctl_tab[i][3], ctl_tab[i][2]})
        end
        lvl = 8'($urandom_range(1, 254));
        wr2(CMD_WRITE_BRIGHT, lvl);
        rd52(1, 8'h00, 1'b1);
        cnt(512, 1'b0);
        `CHK(c, 0)
        wr2(CMD_WRITE_CTRL, 8'h24);
        rd52(2, lvl, 1'b1);
        pwm_tab = '{lvl, 8'h00, 8'hFF};
        foreach (pwm_tab[i]) begin
            wr2(CMD_WRITE_BRIGHT, pwm_tab[i]);
            repeat (256) @(posedge sys_clk);
            cnt(256, 1'b0);
            `CHK(c, int'(pwm_tab[i]))
        end
        host.mode(1'b0);
        rd52(1, 8'hFF, 1'b0);
        host.mode(1'b1);
        host.put(1'b0, CMD_READ_SCAN_LINE);
        note(8'h00, 8'h00);
        host.get();
        note(8'h00, 8'hFE);
        host.get();
        host.put(1'b0, CMD_SET_TEAR_LINE);
        host.put(1'b1, 8'h01);
        host.put(1'b1, 8'h2C);
        wait_rise();
        t0 = $time;
        wait_rise();
        `CHK(int'(($time - t0) / 8), FRAME)
        host.put(1'b0, CMD_SET_TEAR_LINE);
        host.put(1'b1, 8'h00);
        host.put(1'b1, 8'h10);
        wait_rise();
        `CHK(int'(($time - t0) / 8) % FRAME, 0)
        host.put(1'b0, CMD_TEAR_OFF);
        host.put(1'b0, CMD_SET_TEAR_LINE);
        host.put(1'b1, 8'h00);
        host.put(1'b1, 8'h00);
        wait_rise();
        host.put(1'b0, CMD_READ_SCAN_LINE);
        note(8'h00, 8'h00);
        host.get();
        note(8'h00, 8'hFF);
        host.get();
        note(8'h00, 8'hE0);
        host.get();
        host.put(1'b0, CMD_SLEEP_IN);
        `CHK(slp, 1'b1)
        cnt(FRAME + 16, 1'b1);
        `CHK(c, 0)
        rd52(1, 8'h00, 1'b1);
        wrap_up();
    end
endmodule
